/* rtl/bsp_pkg.sv */
package bsp_pkg;
   // ************
   // Geometry
   // ************
   localparam int unsigned BSP_DW = 18;
   localparam int unsigned BSP_AW = 8;
   localparam int unsigned BSP_MW = 2;
   localparam int unsigned BSP_BURST = 4;
   // ************
   // Timing
   // ************
   localparam int unsigned BSP_CAL_CYCLES = 1024;
   localparam int unsigned BSP_STOP_NS = 1000;
   localparam int unsigned BSP_MCLK_MHZ = 100;
   localparam int unsigned BSP_STOP_CYC = (BSP_STOP_NS * BSP_MCLK_MHZ) / 1000;
   localparam logic [1:0] BSP_IMP_DEFAULT = 2'h0;
   localparam logic [1:0] BSP_IMP_CAL = 2'h1;

   typedef enum logic [1:0] {
      BSP_IDLE = 2'b00,
      BSP_W0 = 2'b01,
      BSP_W1 = 2'b11,
      BSP_W2 = 2'b10
   } bsp_beat_t;

   typedef struct packed {
      logic rd_sel_n;
      logic wr_sel_n;
      logic [BSP_AW-1:0] addr;
      logic [BSP_DW-1:0] wdata;
      logic [BSP_MW-1:0] byte_write_mask_n;
   } bsp_req_t;

   typedef struct packed {
      logic [BSP_DW-1:0] q;
      logic q_oe;
      logic echo_ref_pos;
      logic echo_ref_neg;
      logic ready;
      logic [1:0] imp_state;
   } bsp_out_t;
endpackage

/* rtl/bsp_sram_port.sv */
`timescale 1ns/10ps
module bsp_sram_port
   import bsp_pkg::*;
#(
   parameter int unsigned DEPTH = 256,
   parameter int unsigned CAL_CYCLES = BSP_CAL_CYCLES,
   parameter int unsigned STOP_CYC = BSP_STOP_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic k_pos,
   input wire logic k_neg,
   input wire logic c_pos,
   input wire logic c_neg,
   input wire bsp_pkg::bsp_req_t req,
   output bsp_pkg::bsp_out_t dout
);
   import bsp_pkg::*;

   localparam int unsigned CW = $clog2(CAL_CYCLES + 1);
   localparam int unsigned SW = $clog2(STOP_CYC + 1);

   typedef struct packed {
      logic [2:0] kp_s;
      logic [2:0] kn_s;
      logic [2:0] cp_s;
      logic [2:0] cn_s;
      bsp_req_t req_s1;
      bsp_req_t req_s2;
      bsp_beat_t rd_st;
      bsp_beat_t wr_st;
      logic [BSP_AW-1:0] rd_addr;
      logic [BSP_AW-1:0] wr_addr;
      logic [1:0] wr_idx;
      logic [BSP_BURST-1:0][BSP_DW-1:0] wbuf;
      logic [BSP_BURST-1:0][BSP_MW-1:0] wmsk;
      logic wbuf_full;
      logic [BSP_AW-1:0] wbuf_addr;
      logic [BSP_BURST-1:0] wvld;
      logic wr_nxt;
      logic [BSP_AW-1:0] wr_nxt_addr;
      logic [1:0] rd_idx;
      logic rd_pend;
      logic rd_act;
      logic [CW-1:0] cal_cnt;
      logic [SW-1:0] stop_cnt;
      bsp_out_t o;
   } bsp_state_t;

   bsp_state_t s_q;
   bsp_state_t s_d;
   logic [BSP_DW-1:0] mem [DEPTH];
   logic mem_we;
   logic [BSP_AW-1:0] mem_wa;
   logic [BSP_DW-1:0] mem_wd;

   logic kp_rise;
   logic kn_rise;
   logic single_clk;
   logic op_rise_pos;
   logic op_rise_neg;
   logic [BSP_DW-1:0] rd_word;
   logic [BSP_AW-1:0] rd_word_addr;

   // ************
   // Edge finding
   // ************
   assign kp_rise = s_q.kp_s[1] & ~s_q.kp_s[2];
   assign kn_rise = s_q.kn_s[1] & ~s_q.kn_s[2];
   assign single_clk = s_q.cp_s[1] & s_q.cn_s[1];
   assign op_rise_pos = single_clk ? kp_rise : (s_q.cp_s[1] & ~s_q.cp_s[2]);
   assign op_rise_neg = single_clk ? kn_rise : (s_q.cn_s[1] & ~s_q.cn_s[2]);

   // Coherent read word: pending write data overrides array per lane
   always_comb begin
      rd_word_addr = s_q.rd_addr + BSP_AW'(s_q.rd_idx);
      rd_word = mem[rd_word_addr];
      for (int m = 0; m < BSP_MW; m++) begin
         if (s_q.wvld[s_q.rd_idx] && s_q.wr_addr == s_q.rd_addr
             && !s_q.wmsk[s_q.rd_idx][m]) begin
            rd_word[m*(BSP_DW/BSP_MW) +: (BSP_DW/BSP_MW)] =
               s_q.wbuf[s_q.rd_idx][m*(BSP_DW/BSP_MW) +: (BSP_DW/BSP_MW)];
         end
      end
   end

   // ************
   // Next state
   // ************
   always_comb begin
      s_d = s_q;
      mem_we = 1'b0;
      mem_wa = '0;
      mem_wd = '0;
      s_d.kp_s = {s_q.kp_s[1:0], k_pos};
      s_d.kn_s = {s_q.kn_s[1:0], k_neg};
      s_d.cp_s = {s_q.cp_s[1:0], c_pos};
      s_d.cn_s = {s_q.cn_s[1:0], c_neg};
      s_d.req_s1 = req;
      s_d.req_s2 = s_q.req_s1;

      // Clock stop watchdog resets calibration and lock
      if (kp_rise) begin
         s_d.stop_cnt = '0;
      end else if (s_q.stop_cnt < SW'(STOP_CYC)) begin
         s_d.stop_cnt = s_q.stop_cnt + 1'b1;
      end
      if (s_q.stop_cnt == SW'(STOP_CYC)) begin
         s_d.cal_cnt = '0;
      end else if (kp_rise && s_q.cal_cnt < CW'(CAL_CYCLES)) begin
         s_d.cal_cnt = s_q.cal_cnt + 1'b1;
      end
      s_d.o.ready = (s_d.cal_cnt == CW'(CAL_CYCLES));
      s_d.o.imp_state = s_d.o.ready ? BSP_IMP_CAL : BSP_IMP_DEFAULT;

      // Write port: selects seen only on true rise
      if (kp_rise) begin
         unique case (s_q.wr_st)
            BSP_IDLE: begin
               if (!s_q.req_s2.wr_sel_n) begin
                  s_d.wr_st = BSP_W0;
                  s_d.wr_addr = s_q.req_s2.addr;
                  s_d.wvld = '0;
               end
            end
            BSP_W0: begin
               s_d.wr_st = BSP_W1;
               s_d.wbuf[0] = s_q.req_s2.wdata;
               s_d.wmsk[0] = s_q.req_s2.byte_write_mask_n;
               s_d.wvld[0] = 1'b1;
               s_d.wr_idx = 2'h1;
            end
            BSP_W1: begin
               s_d.wbuf[2] = s_q.req_s2.wdata;
               s_d.wmsk[2] = s_q.req_s2.byte_write_mask_n;
               s_d.wvld[2] = 1'b1;
               s_d.wr_st = BSP_W2;
               // Second true rise after a write may start the next one
               if (!s_q.req_s2.wr_sel_n) begin
                  s_d.wr_nxt = 1'b1;
                  s_d.wr_nxt_addr = s_q.req_s2.addr;
               end
            end
            BSP_W2: begin
               if (s_q.wr_nxt) begin
                  s_d.wr_st = BSP_W1;
                  s_d.wr_addr = s_q.wr_nxt_addr;
                  s_d.wr_nxt = 1'b0;
                  s_d.wbuf[0] = s_q.req_s2.wdata;
                  s_d.wmsk[0] = s_q.req_s2.byte_write_mask_n;
                  s_d.wvld = '0;
                  s_d.wvld[0] = 1'b1;
               end else if (!s_q.req_s2.wr_sel_n) begin
                  s_d.wr_st = BSP_W0;
                  s_d.wr_addr = s_q.req_s2.addr;
                  s_d.wvld = '0;
               end else begin
                  s_d.wr_st = BSP_IDLE;
               end
            end
         endcase
      end
      if (kn_rise && (s_q.wr_st == BSP_W1 || s_q.wr_st == BSP_W2)) begin
         s_d.wbuf[s_q.wr_st == BSP_W1 ? 1 : 3] = s_q.req_s2.wdata;
         s_d.wmsk[s_q.wr_st == BSP_W1 ? 1 : 3] = s_q.req_s2.byte_write_mask_n;
         s_d.wvld[s_q.wr_st == BSP_W1 ? 1 : 3] = 1'b1;
         if (s_q.wr_st == BSP_W2) begin
            s_d.wbuf_full = 1'b1;
            s_d.wbuf_addr = s_q.wr_addr;
            s_d.wr_idx = 2'h0;
         end
      end

      // Drain write register into the array, one word per cycle
      if (s_q.wbuf_full && !(kn_rise && s_q.wr_st == BSP_W2)) begin
         mem_we = 1'b1;
         mem_wa = s_q.wbuf_addr + BSP_AW'(s_q.wr_idx);
         for (int m = 0; m < BSP_MW; m++) begin
            mem_wd[m*(BSP_DW/BSP_MW) +: (BSP_DW/BSP_MW)] = s_q.wmsk[s_q.wr_idx][m]
               ? mem[mem_wa][m*(BSP_DW/BSP_MW) +: (BSP_DW/BSP_MW)]
               : s_q.wbuf[s_q.wr_idx][m*(BSP_DW/BSP_MW) +: (BSP_DW/BSP_MW)];
         end
         s_d.wr_idx = s_q.wr_idx + 2'h1;
         if (s_q.wr_idx == 2'h3) begin
            s_d.wbuf_full = 1'b0;
         end
      end

      // Read port, independent of write port
      if (kp_rise) begin
         unique case (s_q.rd_st)
            BSP_IDLE: begin
               if (!s_q.req_s2.rd_sel_n) begin
                  s_d.rd_st = BSP_W0;
                  s_d.rd_addr = s_q.req_s2.addr;
                  s_d.rd_pend = 1'b1;
               end
            end
            BSP_W0: begin
               s_d.rd_st = BSP_IDLE;
            end
            default: begin
               s_d.rd_st = BSP_IDLE;
            end
         endcase
      end
      // First word leaves on the next negative-phase output rise
      if (op_rise_neg && s_q.rd_pend && !s_q.rd_act) begin
         s_d.rd_pend = 1'b0;
         s_d.rd_act = 1'b1;
      end
      if ((op_rise_pos || op_rise_neg) && (s_q.rd_act || (op_rise_neg && s_q.rd_pend))) begin
         s_d.o.q = rd_word;
         s_d.o.q_oe = 1'b1;
         s_d.rd_idx = s_q.rd_idx + 2'h1;
         if (s_q.rd_act && s_q.rd_idx == 2'h3) begin
            s_d.rd_act = 1'b0;
         end
      end else if (op_rise_pos || op_rise_neg) begin
         s_d.o.q_oe = 1'b0;
      end
      if (op_rise_pos) begin
         s_d.o.echo_ref_pos = 1'b1;
         s_d.o.echo_ref_neg = 1'b0;
      end else if (op_rise_neg) begin
         s_d.o.echo_ref_pos = 1'b0;
         s_d.o.echo_ref_neg = 1'b1;
      end
   end

   // ************
   // Registers
   // ************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.kn_s <= '1;
         s_q.cp_s <= '1;
         s_q.cn_s <= '1;
         s_q.req_s1 <= '1;
         s_q.req_s2 <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign dout = s_q.o;

   // ************
   // Checks
   // ************
   a_oe_idle_low: assert property (@(posedge mclk) disable iff (!rst_n)
      (!s_q.rd_act && !s_q.rd_pend && (op_rise_pos || op_rise_neg)) |=> !dout.q_oe)
      else $error("read outputs driven with no burst");
   a_rd_four_words: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(s_q.rd_act) |-> s_q.rd_act [*4])
      else $error("read burst shorter than four cycles");
   a_rd_start_neg: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(s_q.rd_act) |-> $past(op_rise_neg))
      else $error("read burst began off the negative edge");
   a_wr_flush_full: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(s_q.wbuf_full) |-> s_q.wbuf_full [*4])
      else $error("write register drained too early");
   a_echo_opposite: assert property (@(posedge mclk) disable iff (!rst_n)
      (op_rise_pos || op_rise_neg) |=> dout.echo_ref_pos != dout.echo_ref_neg)
      else $error("echo clocks not opposite");
   a_ready_cal: assert property (@(posedge mclk) disable iff (!rst_n)
      dout.ready |-> dout.imp_state == BSP_IMP_CAL)
      else $error("ready before calibration");
   a_stop_relock: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.stop_cnt == SW'(STOP_CYC)) |=> !dout.ready)
      else $error("lock kept across clock stop");
   a_rd_no_retrig: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.rd_st == BSP_W0 && kp_rise) |=> s_q.rd_st == BSP_IDLE)
      else $error("read accepted inside burst");
   a_wr_skip_one: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.wr_st == BSP_W0 && kp_rise) |=> (s_q.wr_st == BSP_W1 && s_q.wr_addr == $past(s_q.wr_addr)))
      else $error("write accepted one rise after a write");
   a_wr_take_next: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.wr_st == BSP_W1 && kp_rise && !s_q.req_s2.wr_sel_n) |=> s_q.wr_nxt)
      else $error("write on second rise lost");
   a_wr_idle_sel: assert property (@(posedge mclk) disable iff (!rst_n)
      (kp_rise && s_q.wr_st == BSP_IDLE && !s_q.req_s2.wr_sel_n) |=> s_q.wr_st == BSP_W0)
      else $error("idle write select not taken");
   a_rd_addr_keep: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.rd_st == BSP_W0 && kp_rise) |=> s_q.rd_addr == $past(s_q.rd_addr))
      else $error("read address replaced inside burst");
   a_rd_indep_wr: assert property (@(posedge mclk) disable iff (!rst_n)
      (kp_rise && !s_q.req_s2.rd_sel_n && s_q.rd_st == BSP_IDLE) |=> s_q.rd_pend)
      else $error("idle read select not taken");
   a_rd_pend_start: assert property (@(posedge mclk) disable iff (!rst_n)
      (op_rise_neg && s_q.rd_pend && !s_q.rd_act) |=> (s_q.rd_act && !s_q.rd_pend))
      else $error("read burst did not start");
   a_oe_first_neg: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(dout.q_oe) |-> $past(op_rise_neg))
      else $error("first read word off the negative edge");
   a_rd_word_out: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.rd_act && (op_rise_pos || op_rise_neg)) |=> dout.q_oe)
      else $error("burst word not driven");
   a_echo_pos_rise: assert property (@(posedge mclk) disable iff (!rst_n)
      op_rise_pos |=> (dout.echo_ref_pos && !dout.echo_ref_neg))
      else $error("echo wrong after positive edge");
   a_wr_done_full: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(s_q.wbuf_full) |-> (s_q.wvld == '1 && $past(kn_rise)))
      else $error("write register full before four words");
   a_imp_default: assert property (@(posedge mclk) disable iff (!rst_n)
      !dout.ready |-> dout.imp_state == BSP_IMP_DEFAULT)
      else $error("impedance state wrong before lock");
   a_stop_cal_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_q.stop_cnt == SW'(STOP_CYC)) |=> s_q.cal_cnt == '0)
      else $error("calibration count kept across clock stop");
   a_cal_step: assert property (@(posedge mclk) disable iff (!rst_n)
      (kp_rise && !dout.ready && s_q.stop_cnt != SW'(STOP_CYC))
      |=> s_q.cal_cnt == $past(s_q.cal_cnt) + 1'b1)
      else $error("calibration count missed a rise");
endmodule

/* bench/bsp_ctrl_model.sv */
`timescale 1ns/10ps
// ************
// Controller side
// ************
module bsp_ctrl_model
   import bsp_pkg::*;
(
   output logic k_pos,
   output logic k_neg,
   output logic c_pos,
   output logic c_neg,
   output bsp_pkg::bsp_req_t req,
   input wire bsp_pkg::bsp_out_t dout
);
   typedef struct packed {logic pos; bsp_out_t o;} bsp_smp_t;
   bsp_smp_t smp[$];
   bit prev_ok = 0;
   bit c_follow = 0;
   initial begin
      k_pos = 1'b0;
      k_neg = 1'b1;
      c_pos = 1'b1;
      c_neg = 1'b1;
      req = '{rd_sel_n: 1'b1, wr_sel_n: 1'b1, default: '0};
   end
   // One input clock period; outputs sampled 50 ns after each rise
   task automatic kcycle(input logic rd_n, input logic wr_n, input logic [BSP_AW-1:0] a,
         input logic [BSP_DW+BSP_MW-1:0] w0, input logic [BSP_DW+BSP_MW-1:0] w1);
      req = '{rd_n, wr_n, a, w0[BSP_DW+BSP_MW-1:BSP_MW], w0[BSP_MW-1:0]};
      #18.75;
      if (prev_ok) smp.push_back('{1'b0, dout});
      #12.5;
      k_pos = 1'b1;
      k_neg = 1'b0;
      if (c_follow) c_pos = 1'b1;
      if (c_follow) c_neg = 1'b0;
      #31.25;
      req = '{1'b1, 1'b1, ~a, w1[BSP_DW+BSP_MW-1:BSP_MW], w1[BSP_MW-1:0]};
      #18.75;
      smp.push_back('{1'b1, dout});
      #12.5;
      k_pos = 1'b0;
      k_neg = 1'b1;
      if (c_follow) c_pos = 1'b0;
      if (c_follow) c_neg = 1'b1;
      #31.25;
      prev_ok = 1;
   endtask
endmodule

/* bench/bsp_sram_port_bench.sv */
`timescale 1ns/10ps
module bsp_sram_port_bench;
   import bsp_pkg::*;
   localparam int CAL = 8;
   localparam int WW = BSP_DW + BSP_MW;
   logic mclk;
   logic rst_n;
   logic k_pos;
   logic k_neg;
   logic c_pos;
   logic c_neg;
   bsp_req_t req;
   bsp_out_t dout;
   int fails = 0;
   int comparisons = 0;
   int seed = 32'hd5413ef6;
   bit fill;
   bit rd_prev;
   bit wr_prev;
   int op;
   logic [BSP_AW-1:0] a;
   logic [BSP_AW-1:0] last_wa;
   logic [BSP_DW-1:0] mem [256];
   logic [BSP_DW:0] exp_q[$];
   logic [BSP_DW:0] pend[$];
   logic [WW-1:0] wq[$];
   bsp_ctrl_model bsp_ctrl_model_i (.k_pos(k_pos), .k_neg(k_neg), .c_pos(c_pos),
      .c_neg(c_neg), .req(req), .dout(dout));
   bsp_sram_port #(.DEPTH(256), .CAL_CYCLES(CAL), .STOP_CYC(40)) bsp_sram_port_i (
      .mclk(mclk), .rst_n(rst_n), .k_pos(k_pos), .k_neg(k_neg), .c_pos(c_pos),
      .c_neg(c_neg), .req(req), .dout(dout));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic drain;
      logic [BSP_DW:0] e;
      while (exp_q.size() > 0 && bsp_ctrl_model_i.smp.size() > 0) begin
         e = exp_q.pop_front();
         check(bsp_ctrl_model_i.smp[0].o.q_oe, e[BSP_DW], "q_oe");
         if (e[BSP_DW]) check(bsp_ctrl_model_i.smp[0].o.q, e[BSP_DW-1:0], "q");
         if (bsp_ctrl_model_i.smp[0].o.ready === 1'b1) check({bsp_ctrl_model_i.smp[0].o.echo_ref_pos,
            bsp_ctrl_model_i.smp[0].o.echo_ref_neg}, {bsp_ctrl_model_i.smp[0].pos,
            !bsp_ctrl_model_i.smp[0].pos}, "echo");
         bsp_ctrl_model_i.smp.delete(0);
      end
   endtask
   task automatic resync;
      exp_q.delete();
      pend.delete();
      wq.delete();
      bsp_ctrl_model_i.smp.delete();
      bsp_ctrl_model_i.prev_ok = 0;
      rd_prev = 0;
      wr_prev = 0;
   endtask
   // Op 0 idle, 1 read, 2 write; one op per true rise
   task automatic step(input int o, input logic [BSP_AW-1:0] ad);
      logic [WW-1:0] w0;
      logic [WW-1:0] w1;
      logic [BSP_DW-1:0] nd;
      logic [BSP_MW-1:0] nm;
      w0 = wq.size() ? wq.pop_front() : WW'($random(seed));
      w1 = wq.size() ? wq.pop_front() : WW'($random(seed));
      exp_q.push_back(pend.size() ? pend.pop_front() : '0);
      if (o == 1 && !rd_prev)
         for (int i = 0; i < 4; i++) pend.push_back({1'b1, mem[8'(ad + i)]});
      rd_prev = (o == 1 && !rd_prev);
      exp_q.push_back(pend.size() ? pend.pop_front() : '0);
      if (o == 2 && !wr_prev) begin
         last_wa = ad;
         for (int i = 0; i < 4; i++) begin
            nd = BSP_DW'($random(seed));
            nm = fill ? '0 : BSP_MW'($random(seed));
            if (!nm[0]) mem[8'(ad + i)][8:0] = nd[8:0];
            if (!nm[1]) mem[8'(ad + i)][17:9] = nd[17:9];
            wq.push_back({nd, nm});
         end
      end
      wr_prev = (o == 2 && !wr_prev);
      bsp_ctrl_model_i.kcycle(o != 1, o != 2, ad, w0, w1);
      drain();
   endtask
   initial begin
      rst_n = 1'b0;
      repeat (16) @(negedge mclk);
      check(dout, '0, "reset value");
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      repeat (CAL - 2) step(0, 0);
      check(dout.ready, 1'b0, "ready early");
      check(dout.imp_state, BSP_IMP_DEFAULT, "imp default");
      repeat (4) step(0, 0);
      check(dout.ready, 1'b1, "ready");
      check(dout.imp_state, BSP_IMP_CAL, "imp cal");
      fill = 1;
      for (int i = 0; i < 64; i++) begin
         step(2, 8'(4 * i));
         step(1, 8'(4 * i));
      end
      fill = 0;
      repeat (200) begin
         op = {$random(seed)} % 4;
         a = 8'(({$random(seed)} % 64) * 4);
         if (op == 3) step(1, last_wa);
         else step(op, a);
      end
      repeat (3) step(0, 0);
      #700;
      check(dout.ready, 1'b0, "clock stop");
      resync();
      repeat (CAL + 2) step(0, 0);
      check(dout.ready, 1'b1, "restart");
      for (int i = 0; i < 8; i++) step(1, 8'(32 * i));
      repeat (3) step(0, 0);
      // Second reset, then output clock pair in use
      rst_n = 1'b0;
      bsp_ctrl_model_i.c_follow = 1;
      bsp_ctrl_model_i.c_pos = 1'b0;
      bsp_ctrl_model_i.c_neg = 1'b1;
      repeat (16) @(negedge mclk);
      check(dout, '0, "second reset");
      rst_n = 1'b1;
      resync();
      repeat (CAL + 2) step(0, 0);
      check(dout.ready, 1'b1, "relock");
      for (int i = 0; i < 6; i++) begin
         step(2, 8'(4 * i + 128));
         step(1, 8'(4 * i + 128));
      end
      repeat (3) step(0, 0);
      report_and_stop();
   end
   initial begin
      #200000;
      fails++;
      report_and_stop();
   end
endmodule
